//--- cbph_bus.sv
// local bus phase, hold and extension operand transfer unit
//
// Summary of operation
// [R1] processor cycle is two system clocks, phase one then phase two
// [R2] phase indicator shows which phase the next clock edge begins
// [R3] reset forces the next clock to begin or repeat phase one
// [R4] late reset edge only delays phase one by one system clock
// [R5] reset source meets setup and hold on reset release
// [R6] data bus floats at the defined point of reset
// [R7] irq, nmi, hold, ext request, error, busy pass a synchroniser
// [R8] status outputs float at logic one while in hold
// [R9] leaving hold drives byte enable and lock at once, valid by send
// [R10] idle directly after a write command keeps driving data
// [R11] data bus stays floated when a read cycle follows
// [R12] ext acknowledge asserted during first operation of each transfer
// [R13] first ext operation is memory read or read of coprocessor port
// [R14] odd operand address moves as two byte memory cycles
// [R15] coprocessor drops request soon after acknowledge to avoid repeat
`timescale 1ns/10ps
module cbph_bus (
    // clock and reset
    input wire logic MCLK,
    input wire logic SRST,
    // asynchronous pins
    input wire logic MASKABLE_IRQ_IN,
    input wire logic NMI_IN,
    input wire logic HOLD_REQ,
    input wire logic EXT_TRANSFER_REQUEST,
    input wire logic ERROR_N_IN,
    input wire logic BUSY_N_IN,
    // synchronous bus pins
    input wire logic READY_N,
    input wire logic [cbph_pkg::DATA_W-1:0] DATA_I,
    output logic [cbph_pkg::DATA_W-1:0] DATA_O,
    output logic DATA_OE,
    output logic [cbph_pkg::ADDR_W-1:0] ADDR_O,
    output logic ADDR_OE,
    output logic MEM_NOT_IO,
    output logic [1:0] STATUS_N_O,
    output logic STATUS_OE,
    output logic UPPER_BYTE_ENABLE_N_O,
    output logic UPPER_BYTE_ENABLE_N_OE,
    output logic LOCK_N_O,
    output logic LOCK_N_OE,
    output logic HOLD_ACKNOWLEDGE,
    output logic EXT_TRANSFER_ACKNOWLEDGE_N,
    output logic PHASE_IND,
    // core side bus requests
    input wire logic REQ_VALID,
    input wire cbph_pkg::cbph_op_t REQ_OP,
    output logic REQ_READY,
    output logic [cbph_pkg::DATA_W-1:0] RD_DATA,
    output logic RD_VALID,
    // core side extension transfer setup
    input wire logic EXT_ENABLE,
    input wire logic EXT_TO_MEM,
    input wire logic [cbph_pkg::ADDR_W-1:0] EXT_OPERAND_ADDR,
    output logic EXT_BUSY,
    // synchronised inputs for the core
    output cbph_pkg::cbph_async_t ASYNC_SYNC
);
    import cbph_pkg::*;

    logic [5:0] sync_q;
    logic hold_s;
    logic ext_req_s;
    logic ph1_next;
    logic tick;
    cbph_state_t state;
    cbph_state_t next_state;
    cbph_op_t op;
    cbph_op_t next_op;
    logic from_ext;
    logic next_from_ext;
    logic [1:0] ext_idx;
    logic [1:0] next_ext_idx;
    logic ext_dir;
    logic [23:0] ext_addr;
    logic [15:0] ext_data;
    logic [15:0] next_ext_data;
    logic ext_go;
    logic ext_last;
    logic done;
    logic data_hold_ti;

    // [R7] async inputs synchronised
    cbph_sync #(.WIDTH(6), .RST_VAL(SYNC_RST_VAL)) u_sync (
        .clk(MCLK),
        .rst(SRST),
        .async_in({BUSY_N_IN, ERROR_N_IN, EXT_TRANSFER_REQUEST, HOLD_REQ,
                   NMI_IN, MASKABLE_IRQ_IN}),
        .sync_out(sync_q)
    );

    assign hold_s = sync_q[2];
    assign ext_req_s = sync_q[3];
    assign ASYNC_SYNC = '{maskable_irq: sync_q[0], nmi: sync_q[1],
                          error_n: sync_q[4], busy_n: sync_q[5]};

    // [R3] reset repeats phase one
    // [R4] synchronous reset, late release shifts phase one a clock
    // [R1] two system clocks per processor cycle
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ph1_next <= 1'b1;
        end else begin
            ph1_next <= ~ph1_next;
        end
    end

    // [R2] indicator from the phase register
    assign PHASE_IND = ph1_next;
    // bus state moves on the edge that begins phase one
    assign tick = ph1_next & ~SRST;

    // one extension operation from step index, direction and operand
    function automatic cbph_op_t ext_op(input logic [1:0] idx,
                                        input logic to_mem,
                                        input logic [23:0] a,
                                        input logic [15:0] d);
        cbph_op_t o;
        o = '{addr: a, write: 1'b0, io: 1'b0, word: ~a[0], lock: 1'b0,
              wdata: d};
        if (!to_mem) begin
            // memory to coprocessor: read operand, then write port
            if (idx == 2'h1 && a[0]) begin
                o.addr = a + 24'h000001;
                o.word = 1'b0;
            end else if (idx != 2'h0) begin
                o = '{addr: EXT_PORT_ADDR, write: 1'b1, io: 1'b1, word: 1'b1,
                      lock: 1'b0, wdata: d};
            end
        end else begin
            // coprocessor to memory: read port, then write operand
            if (idx == 2'h0) begin
                o = '{addr: EXT_PORT_ADDR, write: 1'b0, io: 1'b1, word: 1'b1,
                      lock: 1'b0, wdata: d};
            end else begin
                o.write = 1'b1;
                if (idx == 2'h2) begin
                    o.addr = a + 24'h000001;
                    o.wdata = {8'h00, d[15:8]};
                end else if (a[0]) begin
                    o.wdata = {d[7:0], 8'h00};
                end
            end
        end
        return o;
    endfunction : ext_op

    // [R15] request still high after a transfer starts another one
    assign ext_go = ext_req_s & EXT_ENABLE;
    // [R14] odd operand adds a second byte cycle
    assign ext_last = (ext_idx == (ext_addr[0] ? 2'h2 : 2'h1));
    assign done = (state == CBPH_CMD) & ~READY_N;
    assign REQ_READY = tick & (state == CBPH_IDLE) & ~hold_s & ~ext_go;
    assign EXT_BUSY = from_ext;
    // lanes merged before the edge, as the next step may write them out
    assign next_ext_data = op.write ? ext_data : op.word ? DATA_I :
        op.addr[0] ? {ext_data[15:8], DATA_I[15:8]} :
        {DATA_I[7:0], ext_data[7:0]};

    always_comb begin
        next_state = state;
        next_op = op;
        next_from_ext = from_ext;
        next_ext_idx = ext_idx;
        unique case (state)
            CBPH_IDLE: begin
                if (hold_s) begin
                    next_state = CBPH_HOLD;
                end else if (ext_go) begin
                    // [R13] first operation chosen by direction
                    next_state = CBPH_SEND;
                    next_op = ext_op(2'h0, EXT_TO_MEM, EXT_OPERAND_ADDR,
                                     16'h0000);
                    next_from_ext = 1'b1;
                    next_ext_idx = 2'h0;
                end else if (REQ_VALID) begin
                    next_state = CBPH_SEND;
                    next_op = REQ_OP;
                    next_from_ext = 1'b0;
                end
            end
            CBPH_SEND: begin
                next_state = CBPH_CMD;
            end
            CBPH_CMD: begin
                if (done) begin
                    if (from_ext && !ext_last) begin
                        next_state = CBPH_SEND;
                        next_ext_idx = ext_idx + 2'h1;
                        next_op = ext_op(next_ext_idx, ext_dir, ext_addr,
                                         next_ext_data);
                    end else begin
                        next_state = CBPH_IDLE;
                        next_from_ext = 1'b0;
                    end
                end
            end
            CBPH_HOLD: begin
                if (!hold_s) begin
                    next_state = CBPH_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            state <= CBPH_IDLE;
            op <= '0;
            from_ext <= 1'b0;
            ext_idx <= EXT_IDX_RST;
            ext_dir <= 1'b0;
            ext_addr <= '0;
        end else if (tick) begin
            state <= next_state;
            op <= next_op;
            from_ext <= next_from_ext;
            ext_idx <= next_ext_idx;
            if (state == CBPH_IDLE && next_from_ext) begin
                ext_dir <= EXT_TO_MEM;
                ext_addr <= EXT_OPERAND_ADDR;
            end
        end
    end

    // read data capture, byte lanes merged for odd operands
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ext_data <= '0;
            RD_DATA <= '0;
            RD_VALID <= 1'b0;
        end else begin
            RD_VALID <= 1'b0;
            if (tick && done && !op.write) begin
                if (!from_ext) begin
                    RD_DATA <= DATA_I;
                    RD_VALID <= 1'b1;
                end else begin
                    ext_data <= next_ext_data;
                end
            end
        end
    end

    // [R10] one idle state after a write command keeps data driven
    // [R11] a read cycle never drives data
    assign data_hold_ti = done & op.write & (next_state == CBPH_IDLE);

    // pins are registered from the next bus state
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            // [R6] data floated through reset
            DATA_OE <= 1'b0;
            DATA_O <= '0;
            ADDR_O <= '0;
            ADDR_OE <= 1'b0;
            MEM_NOT_IO <= 1'b1;
            STATUS_N_O <= STAT_PASSIVE;
            STATUS_OE <= 1'b0;
            UPPER_BYTE_ENABLE_N_O <= 1'b1;
            UPPER_BYTE_ENABLE_N_OE <= 1'b0;
            LOCK_N_O <= 1'b1;
            LOCK_N_OE <= 1'b0;
            HOLD_ACKNOWLEDGE <= 1'b0;
            EXT_TRANSFER_ACKNOWLEDGE_N <= 1'b1;
        end else if (tick) begin
            DATA_O <= next_op.wdata;
            DATA_OE <= ((next_state == CBPH_SEND || next_state == CBPH_CMD)
                        && next_op.write) || data_hold_ti;
            ADDR_O <= next_op.addr;
            ADDR_OE <= (next_state != CBPH_HOLD);
            MEM_NOT_IO <= ~next_op.io;
            // [R8] status floats at logic one in hold
            STATUS_OE <= (next_state != CBPH_HOLD);
            STATUS_N_O <= (next_state == CBPH_SEND) ?
                          (next_op.write ? STAT_WRITE : STAT_READ) :
                          STAT_PASSIVE;
            // [R9] driven as soon as hold ends, valid from send
            UPPER_BYTE_ENABLE_N_OE <= (next_state != CBPH_HOLD);
            LOCK_N_OE <= (next_state != CBPH_HOLD);
            if (next_state == CBPH_SEND || next_state == CBPH_CMD) begin
                UPPER_BYTE_ENABLE_N_O <= ~(next_op.word | next_op.addr[0]);
                LOCK_N_O <= ~next_op.lock;
            end else begin
                UPPER_BYTE_ENABLE_N_O <= 1'b1;
                LOCK_N_O <= 1'b1;
            end
            HOLD_ACKNOWLEDGE <= (next_state == CBPH_HOLD);
            // [R12] acknowledge only during the first operation
            EXT_TRANSFER_ACKNOWLEDGE_N <= ~(next_from_ext &&
                (next_ext_idx == 2'h0) &&
                (next_state == CBPH_SEND || next_state == CBPH_CMD));
        end
    end
endmodule : cbph_bus

//--- cbph_pkg.sv
// package: shared constants and types of the local bus phase and hold unit
package cbph_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    // processor cycle is two system clocks, phase one then phase two
    localparam int SYS_CLK_PER_PROC = 2;
    // fixed coprocessor data port for extension operand transfers
    localparam logic [23:0] EXT_PORT_ADDR = 24'h0000FA;
    // bus status codes, status bit one then status bit zero, active low
    localparam logic [1:0] STAT_PASSIVE = 2'h3;
    localparam logic [1:0] STAT_READ = 2'h2;
    localparam logic [1:0] STAT_WRITE = 2'h1;
    // synchroniser reset levels: irq, nmi, hold, ext req, error_n, busy_n
    localparam logic [5:0] SYNC_RST_VAL = 6'h30;
    localparam logic [1:0] EXT_IDX_RST = 2'h0;

    typedef enum logic [1:0] {
        CBPH_IDLE = 2'b00,
        CBPH_SEND = 2'b01,
        CBPH_CMD = 2'b10,
        CBPH_HOLD = 2'b11
    } cbph_state_t;

    typedef struct packed {
        logic [23:0] addr;
        logic write;
        logic io;
        logic word;
        logic lock;
        logic [15:0] wdata;
    } cbph_op_t;

    typedef struct packed {
        logic maskable_irq;
        logic nmi;
        logic error_n;
        logic busy_n;
    } cbph_async_t;
endpackage : cbph_pkg

//--- cbph_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module cbph_sync #(
    parameter int WIDTH = 6,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // asynchronous in, filtered out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1 <= RST_VAL;
            s2 <= RST_VAL;
            s3 <= RST_VAL;
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // a change only counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_out <= RST_VAL;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2[i] == s3[i]) begin
                    sync_out[i] <= s3[i];
                end
            end
        end
    end
endmodule : cbph_sync

//--- cbph_bus_asserts.sv
// checker: phase, hold and extension transfer behaviour at the unit pins
`timescale 1ns/10ps
module cbph_chk
    import cbph_pkg::*;
(
    // clock and reset
    input wire logic MCLK,
    input wire logic SRST,
    // inputs watched
    input wire logic HOLD_REQ,
    input wire logic READY_N,
    // pins watched
    input wire logic DATA_OE,
    input wire logic [cbph_pkg::ADDR_W-1:0] ADDR_O,
    input wire logic MEM_NOT_IO,
    input wire logic [1:0] STATUS_N_O,
    input wire logic STATUS_OE,
    input wire logic UPPER_BYTE_ENABLE_N_OE,
    input wire logic LOCK_N_OE,
    input wire logic HOLD_ACKNOWLEDGE,
    input wire logic EXT_TRANSFER_ACKNOWLEDGE_N,
    input wire logic PHASE_IND
);
    logic wr_seen;
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SRST);
    // remembers whether the last send state was a write
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            wr_seen <= 1'b0;
        end else if (STATUS_OE && STATUS_N_O != STAT_PASSIVE) begin
            wr_seen <= (STATUS_N_O == STAT_WRITE);
        end
    end
    sequence s_wr_done;
        wr_seen && PHASE_IND && !READY_N && DATA_OE;
    endsequence
    sequence s_ack_start;
        $fell(EXT_TRANSFER_ACKNOWLEDGE_N);
    endsequence
    a_phase_alternates: assert property (
        !SRST |=> PHASE_IND != $past(PHASE_IND))
        else $error("phase indicator did not alternate");
    a_reset_release: assert property (
        $fell(SRST) |-> PHASE_IND && !DATA_OE && !STATUS_OE)
        else $error("reset release not in phase one or bus driven");
    a_hold_sync: assert property (
        $rose(HOLD_REQ) && !HOLD_ACKNOWLEDGE |=> !HOLD_ACKNOWLEDGE [*2])
        else $error("hold acknowledged without synchronisation");
    a_hold_floats: assert property (
        HOLD_ACKNOWLEDGE |-> !STATUS_OE && STATUS_N_O == STAT_PASSIVE)
        else $error("status not floated at logic one in hold");
    a_hold_exit: assert property (
        $fell(HOLD_ACKNOWLEDGE) |-> UPPER_BYTE_ENABLE_N_OE && LOCK_N_OE)
        else $error("byte enable or lock not driven after hold");
    a_write_tail: assert property (
        s_wr_done |=> DATA_OE [*2])
        else $error("data bus released in idle after write");
    a_read_floats: assert property (
        STATUS_OE && STATUS_N_O == STAT_READ |-> !DATA_OE ##1 !DATA_OE)
        else $error("data bus driven during read");
    a_ack_first_op: assert property (
        s_ack_start |-> STATUS_OE && STATUS_N_O == STAT_READ
            && (MEM_NOT_IO || ADDR_O == EXT_PORT_ADDR))
        else $error("acknowledge not on first read of transfer");
    a_ack_span: assert property (
        s_ack_start |-> !EXT_TRANSFER_ACKNOWLEDGE_N [*4])
        else $error("acknowledge shorter than first operation");
endmodule : cbph_chk

bind cbph_bus cbph_chk u_chk (.*);

//--- cbph_far.sv
// far side model: bus controller and memory answering local bus cycles
`timescale 1ns/10ps
module cbph_far
    import cbph_pkg::*;
(
    // clock and wait setting
    input wire logic MCLK,
    input wire logic [3:0] waits,
    // bus pins from the unit
    input wire logic [1:0] STATUS_N_O,
    input wire logic STATUS_OE,
    input wire logic [cbph_pkg::ADDR_W-1:0] ADDR_O,
    input wire logic [cbph_pkg::DATA_W-1:0] DATA_O,
    // answers
    output logic READY_N,
    output logic [cbph_pkg::DATA_W-1:0] DATA_I
);
    int n = 0;
    int nops = 0;
    logic wr;
    logic [23:0] la;
    logic [15:0] ld;
    initial begin
        READY_N = 1'b1;
        DATA_I = 16'h0000;
    end
    // read data is the inverted address; undriven data toggles each cycle
    always @(posedge MCLK) begin
        #1;
        READY_N = 1'b1;
        DATA_I = ~DATA_I;
        if (n == 1) begin
            READY_N = 1'b0;
            DATA_I = ~la[15:0];
            if (wr) begin
                ld = DATA_O;
            end
            nops++;
        end
        if (n != 0) begin
            n--;
        end else if (STATUS_OE && STATUS_N_O != STAT_PASSIVE) begin
            n = 3 + 2 * waits;
            wr = (STATUS_N_O == STAT_WRITE);
            la = ADDR_O;
        end
    end
endmodule : cbph_far

//--- tb_top.sv
// testbench: reset phase, sync, core, hold and extension transfers
`timescale 1ns/10ps
module tb_top;
    import cbph_pkg::*;
    logic MCLK = 1'b0;
    logic SRST, MASKABLE_IRQ_IN, NMI_IN, HOLD_REQ, EXT_TRANSFER_REQUEST;
    logic ERROR_N_IN, BUSY_N_IN, READY_N, DATA_OE, ADDR_OE, MEM_NOT_IO;
    logic STATUS_OE, UPPER_BYTE_ENABLE_N_O, UPPER_BYTE_ENABLE_N_OE;
    logic LOCK_N_O, LOCK_N_OE, HOLD_ACKNOWLEDGE, EXT_TRANSFER_ACKNOWLEDGE_N;
    logic PHASE_IND, REQ_VALID, REQ_READY, RD_VALID, EXT_ENABLE, EXT_TO_MEM;
    logic EXT_BUSY;
    logic [1:0] STATUS_N_O;
    logic [15:0] DATA_I, DATA_O, RD_DATA;
    logic [23:0] ADDR_O, EXT_OPERAND_ADDR;
    logic [3:0] waits;
    cbph_op_t REQ_OP;
    cbph_async_t ASYNC_SYNC;
    int n_fail = 0;
    int total_checks = 0;

    cbph_bus dut (.*);
    cbph_far m (.*);

    always #5 MCLK = ~MCLK;

    task automatic chk(input logic [47:0] s, input logic [47:0] e);
        total_checks++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("checks=%0d failures=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    // inputs always move 1 ns after the edge
    task automatic tick();
        @(posedge MCLK);
        #1;
    endtask : tick

    // release placed off the edge, always with phase one held by reset
    task automatic t_reset(input int n);
        SRST = 1'b1;
        repeat (n) tick();
        chk({PHASE_IND, DATA_OE, ASYNC_SYNC}, 6'h23);
        SRST = 1'b0;
        tick();
        chk(PHASE_IND, 1'b0);
        tick();
        chk(PHASE_IND, 1'b1);
    endtask : t_reset

    task automatic t_async();
        {MASKABLE_IRQ_IN, NMI_IN, ERROR_N_IN, BUSY_N_IN} = 4'hC;
        chk(ASYNC_SYNC, 4'h3);
        repeat (8) tick();
        chk(ASYNC_SYNC, 4'hC);
        {MASKABLE_IRQ_IN, NMI_IN, ERROR_N_IN, BUSY_N_IN} = 4'h3;
        repeat (8) tick();
        chk(ASYNC_SYNC, 4'h3);
    endtask : t_async

    task automatic xfer(input logic w, input logic [23:0] a,
                        input logic [15:0] d);
        int k;
        int n0 = m.nops;
        REQ_OP = '{a, w, 1'b0, 1'b1, w, d};
        REQ_VALID = 1'b1;
        for (k = 0; k < 60 && REQ_READY !== 1'b1; k++) tick();
        tick();
        REQ_VALID = 1'b0;
        chk({LOCK_N_O, STATUS_N_O},
            w ? {1'b0, STAT_WRITE} : {1'b1, STAT_READ});
        for (k = 0; k < 60 && m.nops == n0; k++) tick();
        if (w) begin
            chk({m.la, m.ld}, {a, d});
        end else begin
            for (k = 0; k < 9 && RD_VALID !== 1'b1; k++) tick();
            chk({RD_VALID, RD_DATA}, {1'b1, ~a[15:0]});
        end
    endtask : xfer

    task automatic t_hold();
        int k;
        HOLD_REQ = 1'b1;
        for (k = 0; k < 30 && HOLD_ACKNOWLEDGE !== 1'b1; k++) tick();
        chk({STATUS_OE, STATUS_N_O, ADDR_OE, REQ_READY}, 5'h0C);
        HOLD_REQ = 1'b0;
        for (k = 0; k < 30 && HOLD_ACKNOWLEDGE !== 1'b0; k++) tick();
        chk({UPPER_BYTE_ENABLE_N_OE, LOCK_N_OE, STATUS_N_O,
             UPPER_BYTE_ENABLE_N_O, LOCK_N_O}, 6'h3F);
    endtask : t_hold

    task automatic t_ext(input logic tm, input logic [23:0] a, fa,
                         input logic fm, input int cnt,
                         input logic [23:0] la, input logic [15:0] ld);
        int k;
        int n0 = m.nops;
        EXT_TO_MEM = tm;
        EXT_OPERAND_ADDR = a;
        EXT_ENABLE = 1'b1;
        EXT_TRANSFER_REQUEST = 1'b1;
        for (k = 0; k < 60 && EXT_TRANSFER_ACKNOWLEDGE_N !== 1'b0; k++) tick();
        // request dropped at once so only one transfer runs
        EXT_TRANSFER_REQUEST = 1'b0;
        chk({EXT_BUSY, MEM_NOT_IO, ADDR_O}, {1'b1, fm, fa});
        chk({UPPER_BYTE_ENABLE_N_O, LOCK_N_O}, 2'h1);
        for (k = 0; k < 99 && m.nops < n0 + cnt; k++) tick();
        repeat (12) tick();
        chk(m.nops - n0, cnt);
        chk({m.la, m.ld}, {la, ld});
        EXT_ENABLE = 1'b0;
        tick();
    endtask : t_ext

    initial begin
        {MASKABLE_IRQ_IN, NMI_IN, HOLD_REQ, EXT_TRANSFER_REQUEST} = 4'h0;
        {ERROR_N_IN, BUSY_N_IN, REQ_VALID, EXT_ENABLE, EXT_TO_MEM} = 5'h18;
        REQ_OP = '0;
        EXT_OPERAND_ADDR = 24'h000000;
        waits = 4'h0;
        t_reset(12);
        t_async();
        xfer(1'b1, 24'h000100, 16'h1234);
        waits = 4'h1;
        xfer(1'b0, 24'h000200, 16'h0000);
        waits = 4'h0;
        t_hold();
        // odd operand: two byte reads, then port write of the joined word
        t_ext(1'b0, 24'h000301, 24'h000301, 1'b1, 3, 24'h0000FA, 16'hFDFC);
        t_ext(1'b1, 24'h000400, 24'h0000FA, 1'b0, 2, 24'h000400, 16'hFF05);
        t_reset(3);
        xfer(1'b0, 24'h000A5C, 16'h0000);
        report_and_stop();
    end

    initial begin
        #100000;
        n_fail++;
        report_and_stop();
    end
endmodule : tb_top
